// ### ldtp_cfg.svh
// register offsets, field positions, reset values and timing limits of the drive timing block
// assumes a 32-bit word-aligned register map decoded on the low address byte
`ifndef LDTP_CFG_SVH
`define LDTP_CFG_SVH
`define LDTP_CTRL_OFS 8'h00
`define LDTP_TIMING_OFS 8'h04
`define LDTP_LINES_OFS 8'h08
`define LDTP_PART1_OFS 8'h0c
`define LDTP_PART2_OFS 8'h10
`define LDTP_GPOS_A_OFS 8'h14
`define LDTP_GPOS_B_OFS 8'h18
`define LDTP_GNEG_A_OFS 8'h1c
`define LDTP_GNEG_B_OFS 8'h20
`define LDTP_VREF_OFS 8'h24
`define LDTP_STATUS_OFS 8'h28
`define LDTP_CTRL_EN_BIT 0
`define LDTP_CTRL_LINE_INV_BIT 1
`define LDTP_CTRL_EIGHT_BIT 2
`define LDTP_CTRL_PARTIAL_BIT 3
`define LDTP_LCC_LSB 0
`define LDTP_PRESCALE_LSB 8
`define LDTP_SPAN_LSB 16
`define LDTP_NL_LSB 0
`define LDTP_FP_LSB 16
`define LDTP_BP_LSB 24
`define LDTP_PSTART_LSB 0
`define LDTP_PEND_LSB 16
`define LDTP_CTRL_RST 4'h0
`define LDTP_TIMING_RST 9'h019
`define LDTP_NL_RST 9'h1b0
`define LDTP_FP_RST 8'h02
`define LDTP_BP_RST 8'h0e
`define LDTP_VREF_RST 3'h0
`define LDTP_MIN_LINE_CLOCKS 5'h10
`define LDTP_NONLIT_PIXEL 18'h00000
`define LDTP_LOW_TAP_BASE 5'h03
`define LDTP_HIGH_TAP_BASE 5'h19
`define LDTP_GRAY_TOP 31
`endif

// ### ldtp_pkg.sv
// shared types of the drive timing block
// constants live in ldtp_cfg.svh
package ldtp_pkg;
   typedef struct packed {
      logic [1:0] inversion_line_span;
      logic [1:0] clock_prescale_select;
      logic [4:0] line_clock_count;
   } ldtp_timing_s;

   // upper 24 bits match the layout of a gamma "a" register word
   typedef struct packed {
      logic [3:0][1:0] ratio_tap_select;
      logic [2:0] gradient_high;
      logic [2:0] gradient_low;
      logic [4:0] amplitude_bottom;
      logic [4:0] amplitude_top;
      logic [5:0][2:0] fine_level;
   } ldtp_gamma_s;

   typedef enum logic [1:0] {
      LDTP_PH_BACK = 2'b00,
      LDTP_PH_DISP = 2'b01,
      LDTP_PH_FRONT = 2'b10
   } ldtp_phase_e;
endpackage

// ### ldtp_line_timer.sv
// line period generator: prescales the oscillator clock and counts clocks per line
// assumes clk_i is the oscillator and the timing fields come from registers on the same clock
`timescale 1ns/1ps
`include "ldtp_cfg.svh"
module ldtp_line_timer (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic run_i,
   input wire ldtp_pkg::ldtp_timing_s timing_i,
   output logic line_start_o
);
   logic [1:0] pre_q;
   logic [4:0] cnt_q;
   logic [7:0] cyc_q;
   logic seen_q;
   // codes below the usable range would make lines too short to drive, so they clamp
   wire [4:0] period_w = (timing_i.line_clock_count < `LDTP_MIN_LINE_CLOCKS) ?
                         `LDTP_MIN_LINE_CLOCKS : timing_i.line_clock_count;
   wire [1:0] pre_lim_w = timing_i.clock_prescale_select;
   wire tick_w = run_i && (pre_q == pre_lim_w);
   assign line_start_o = tick_w && (cnt_q == period_w - 5'h01);

   always_ff @(posedge clk_i)
   begin
      if (reset_i || !run_i)
      begin
         pre_q <= 2'h0;
         cnt_q <= 5'h00;
      end
      else
      begin
         pre_q <= tick_w ? 2'h0 : pre_q + 2'h1;
         if (tick_w)
            cnt_q <= line_start_o ? 5'h00 : cnt_q + 5'h01;
      end
   end

   // helper: raw clocks since the last line start, valid while settings hold
   always_ff @(posedge clk_i)
   begin
      if (reset_i || !run_i || $changed(timing_i))
      begin
         cyc_q <= 8'h00;
         seen_q <= 1'b0;
      end
      else
      begin
         cyc_q <= line_start_o ? 8'h00 : cyc_q + 8'h01;
         seen_q <= seen_q | line_start_o;
      end
   end

   line_len_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (line_start_o && seen_q) |-> (cyc_q == 8'(period_w * (pre_lim_w + 2'h1)) - 8'h01))
      else $error("line period does not match clocks per line and prescale");
   half_rate_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (run_i && pre_lim_w == 2'h1 && $stable(timing_i) && $past(tick_w)) |-> !tick_w)
      else $error("prescale by two produced back to back ticks");
endmodule

// ### ldtp_gamma_sel.sv
// per-polarity gamma set selection and eight-colour grayscale shutdown
// assumes both gamma sets and the mode bits come from registers on the same clock
`timescale 1ns/1ps
`include "ldtp_cfg.svh"
module ldtp_gamma_sel (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic polarity_i,
   input wire logic eight_colour_i,
   input wire ldtp_pkg::ldtp_gamma_s pos_i,
   input wire ldtp_pkg::ldtp_gamma_s neg_i,
   output ldtp_pkg::ldtp_gamma_s gamma_o,
   output logic [31:0] gray_enable_o,
   output logic [4:0] low_tap_gray_o,
   output logic [4:0] high_tap_gray_o
);
   ldtp_pkg::ldtp_gamma_s sel_w;
   ldtp_pkg::ldtp_gamma_s eff_w;
   // same set serves red, green and blue
   assign sel_w = polarity_i ? neg_i : pos_i;
   always_comb
   begin
      eff_w = sel_w;
      if (eight_colour_i)
      begin
         eff_w.fine_level = '0;
         eff_w.gradient_low = 3'h0;
         eff_w.gradient_high = 3'h0;
         eff_w.ratio_tap_select = '0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         gamma_o <= '0;
         gray_enable_o <= 32'h00000000;
         low_tap_gray_o <= `LDTP_LOW_TAP_BASE;
         high_tap_gray_o <= `LDTP_HIGH_TAP_BASE;
      end
      else
      begin
         gamma_o <= eff_w;
         // only the two end levels stay powered in eight-colour mode
         gray_enable_o <= eight_colour_i ? 32'h80000001 : 32'hffffffff;
         low_tap_gray_o <= `LDTP_LOW_TAP_BASE + {3'h0, eff_w.ratio_tap_select[1]};
         high_tap_gray_o <= `LDTP_HIGH_TAP_BASE + {3'h0, eff_w.ratio_tap_select[2]};
      end
   end

   pol_set_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (!eight_colour_i) |=> gamma_o == ($past(polarity_i) ? $past(neg_i) : $past(pos_i)))
      else $error("gamma set does not follow drive polarity");
   eight_gray_a: assert property (@(posedge clk_i) disable iff (reset_i)
      eight_colour_i |=> (gray_enable_o == 32'h80000001) && (gamma_o.fine_level == '0))
      else $error("intermediate levels active in eight-colour mode");
   tap_range_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (low_tap_gray_o <= 5'h06) && (high_tap_gray_o >= 5'h19) && (high_tap_gray_o <= 5'h1c))
      else $error("tap grayscale outside its group");
endmodule

// ### ldtp_top.sv
// drive timing, polarity alternation, pixel reduction and gamma hold for a small tft driver
// assumes clk_i is the rc oscillator, an ahb-lite master on the same clock, pixels on the same clock
// Notes on behaviour
// - eight-colour ignores gamma trims, only end levels
// - eight-colour copies each component msb downward
// - line inversion toggles every span plus one
// - in line inversion, porch lines freeze alternation, resume at display
// - frame inversion toggles once per frame
// - line inversion still inserts porch blank interval
// - frame equals lines plus porches times line
// - line period in clocks, usable 16 to 31
// - prescale code one halves the frame rate
// - partial display drives unselected lines non-lit
// - separate polarity gamma sets, shared by rgb
// - gamma field widths five, three and two
// - tap selects pick grayscale for fine trims
`timescale 1ns/1ps
`include "ldtp_cfg.svh"
module ldtp_top (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic [31:0] hrdata_o,
   output logic hresp_o,
   input wire logic [17:0] pixel_i,
   output logic [17:0] pixel_o,
   output logic drive_polarity_o,
   output logic frame_start_o,
   output logic line_start_o,
   output logic display_line_o,
   output logic non_lit_o,
   output ldtp_pkg::ldtp_gamma_s gamma_o,
   output logic [31:0] gray_enable_o,
   output logic [4:0] low_tap_gray_o,
   output logic [4:0] high_tap_gray_o,
   output logic [2:0] reference_voltage_setting_o
);
   function automatic logic [3:0] reg_index(input logic [7:0] a);
      case (a)
         `LDTP_CTRL_OFS: reg_index = 4'h1;
         `LDTP_TIMING_OFS: reg_index = 4'h2;
         `LDTP_LINES_OFS: reg_index = 4'h3;
         `LDTP_PART1_OFS: reg_index = 4'h4;
         `LDTP_PART2_OFS: reg_index = 4'h5;
         `LDTP_GPOS_A_OFS: reg_index = 4'h6;
         `LDTP_GPOS_B_OFS: reg_index = 4'h7;
         `LDTP_GNEG_A_OFS: reg_index = 4'h8;
         `LDTP_GNEG_B_OFS: reg_index = 4'h9;
         `LDTP_VREF_OFS: reg_index = 4'ha;
         `LDTP_STATUS_OFS: reg_index = 4'hb;
         default: reg_index = 4'h0;
      endcase
   endfunction

   // bus slave state
   logic wr_pend_q;
   logic rd_wait_q;
   logic [3:0] wr_idx_q;
   logic [3:0] rd_idx_q;

   // registers
   logic [3:0] ctrl_q;
   ldtp_pkg::ldtp_timing_s timing_q;
   logic [8:0] panel_line_count_q;
   logic [7:0] front_porch_lines_q;
   logic [7:0] back_porch_lines_q;
   logic [8:0] p1_start_q;
   logic [8:0] p1_end_q;
   logic [8:0] p2_start_q;
   logic [8:0] p2_end_q;
   ldtp_pkg::ldtp_gamma_s gpos_q;
   ldtp_pkg::ldtp_gamma_s gneg_q;
   logic [2:0] vref_q;

   // sequencer state
   logic [10:0] line_idx_q;
   logic line_evt_q;
   logic [1:0] span_cnt_q;
   logic polarity_q;
   logic [31:0] rd_mux_w;

   wire req_w = hsel_i && hready_i && htrans_i[1];
   wire [3:0] req_idx_w = reg_index(haddr_i[7:0]);
   wire en_w = ctrl_q[`LDTP_CTRL_EN_BIT];
   wire line_mode_w = ctrl_q[`LDTP_CTRL_LINE_INV_BIT];
   wire eight_w = ctrl_q[`LDTP_CTRL_EIGHT_BIT];
   wire partial_w = ctrl_q[`LDTP_CTRL_PARTIAL_BIT];

   // only whole-word writes are issued, hsize is accepted as is
   assign hreadyout_o = !rd_wait_q;
   assign hresp_o = 1'b0;

   // frame length in line periods: driven lines plus both porches
   wire [10:0] total_w = 11'(panel_line_count_q) + 11'(front_porch_lines_q) + 11'(back_porch_lines_q);
   wire [10:0] disp_lo_w = 11'(back_porch_lines_q);
   wire [10:0] disp_hi_w = disp_lo_w + 11'(panel_line_count_q);
   wire disp_w = (line_idx_q >= disp_lo_w) && (line_idx_q < disp_hi_w);
   wire [8:0] disp_row_w = 9'(line_idx_q - disp_lo_w);
   wire in_p1_w = (disp_row_w >= p1_start_q) && (disp_row_w <= p1_end_q);
   wire in_p2_w = (disp_row_w >= p2_start_q) && (disp_row_w <= p2_end_q);
   wire lit_w = disp_w && (!partial_w || in_p1_w || in_p2_w);
   wire frame_wrap_w = (line_idx_q >= total_w - 11'h001);
   ldtp_pkg::ldtp_phase_e phase_w;
   assign phase_w = disp_w ? ldtp_pkg::LDTP_PH_DISP :
                    (line_idx_q < disp_lo_w) ? ldtp_pkg::LDTP_PH_BACK : ldtp_pkg::LDTP_PH_FRONT;

   assign frame_start_o = line_evt_q && (line_idx_q == 11'h000);
   assign display_line_o = disp_w;
   assign drive_polarity_o = polarity_q;
   assign reference_voltage_setting_o = vref_q;

   always_comb
   begin
      unique case (rd_idx_q)
         4'h1: rd_mux_w = {28'h0000000, ctrl_q};
         4'h2: rd_mux_w = {14'h0000, timing_q.inversion_line_span, 6'h00,
                           timing_q.clock_prescale_select, 3'h0, timing_q.line_clock_count};
         4'h3: rd_mux_w = {back_porch_lines_q, front_porch_lines_q, 7'h00, panel_line_count_q};
         4'h4: rd_mux_w = {7'h00, p1_end_q, 7'h00, p1_start_q};
         4'h5: rd_mux_w = {7'h00, p2_end_q, 7'h00, p2_start_q};
         4'h6: rd_mux_w = {8'h00, gpos_q[41:18]};
         4'h7: rd_mux_w = {14'h0000, gpos_q[17:0]};
         4'h8: rd_mux_w = {8'h00, gneg_q[41:18]};
         4'h9: rd_mux_w = {14'h0000, gneg_q[17:0]};
         4'ha: rd_mux_w = {29'h00000000, vref_q};
         4'hb: rd_mux_w = {16'h0000, polarity_q, 1'b0, phase_w, 1'b0, line_idx_q};
         default: rd_mux_w = 32'h00000000;
      endcase
   end

   // reads wait one cycle so a write in the previous data phase is already stored
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         wr_pend_q <= 1'b0;
         rd_wait_q <= 1'b0;
         wr_idx_q <= 4'h0;
         rd_idx_q <= 4'h0;
         hrdata_o <= 32'h00000000;
      end
      else
      begin
         wr_pend_q <= req_w && hwrite_i;
         rd_wait_q <= req_w && !hwrite_i;
         wr_idx_q <= req_idx_w;
         if (req_w && !hwrite_i)
            rd_idx_q <= req_idx_w;
         if (rd_wait_q)
            hrdata_o <= rd_mux_w;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         ctrl_q <= `LDTP_CTRL_RST;
         timing_q <= `LDTP_TIMING_RST;
         panel_line_count_q <= `LDTP_NL_RST;
         front_porch_lines_q <= `LDTP_FP_RST;
         back_porch_lines_q <= `LDTP_BP_RST;
         p1_start_q <= 9'h000;
         p1_end_q <= 9'h000;
         p2_start_q <= 9'h000;
         p2_end_q <= 9'h000;
         gpos_q <= '0;
         gneg_q <= '0;
         vref_q <= `LDTP_VREF_RST;
      end
      else if (wr_pend_q)
      begin
         unique case (wr_idx_q)
            4'h1: ctrl_q <= hwdata_i[3:0];
            4'h2: timing_q <= {hwdata_i[`LDTP_SPAN_LSB +: 2], hwdata_i[`LDTP_PRESCALE_LSB +: 2],
                               hwdata_i[`LDTP_LCC_LSB +: 5]};
            4'h3:
            begin
               panel_line_count_q <= hwdata_i[`LDTP_NL_LSB +: 9];
               front_porch_lines_q <= hwdata_i[`LDTP_FP_LSB +: 8];
               back_porch_lines_q <= hwdata_i[`LDTP_BP_LSB +: 8];
            end
            4'h4:
            begin
               p1_start_q <= hwdata_i[`LDTP_PSTART_LSB +: 9];
               p1_end_q <= hwdata_i[`LDTP_PEND_LSB +: 9];
            end
            4'h5:
            begin
               p2_start_q <= hwdata_i[`LDTP_PSTART_LSB +: 9];
               p2_end_q <= hwdata_i[`LDTP_PEND_LSB +: 9];
            end
            4'h6: gpos_q <= {hwdata_i[23:0], gpos_q[17:0]};
            4'h7: gpos_q <= {gpos_q[41:18], hwdata_i[17:0]};
            4'h8: gneg_q <= {hwdata_i[23:0], gneg_q[17:0]};
            4'h9: gneg_q <= {gneg_q[41:18], hwdata_i[17:0]};
            4'ha: vref_q <= hwdata_i[2:0];
            default: ctrl_q <= ctrl_q;
         endcase
      end
   end

   ldtp_line_timer u_line_timer (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .run_i(en_w),
      .timing_i(timing_q),
      .line_start_o(line_start_o)
   );

   // line index advances at each line start; the event flag marks the first cycle of the new line
   always_ff @(posedge clk_i)
   begin
      if (reset_i || !en_w)
      begin
         line_idx_q <= 11'h000;
         line_evt_q <= 1'b0;
      end
      else
      begin
         line_evt_q <= line_start_o;
         if (line_start_o)
            line_idx_q <= frame_wrap_w ? 11'h000 : line_idx_q + 11'h001;
      end
   end

   // polarity keeps its value across disable so alternation is not biased by restarts
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         polarity_q <= 1'b0;
         span_cnt_q <= 2'h0;
      end
      else if (line_evt_q && !line_mode_w && line_idx_q == 11'h000)
         polarity_q <= !polarity_q;
      else if (line_evt_q && line_mode_w && disp_w)
      begin
         if (line_idx_q == disp_lo_w)
            span_cnt_q <= 2'h0;
         else if (span_cnt_q == timing_q.inversion_line_span)
         begin
            polarity_q <= !polarity_q;
            span_cnt_q <= 2'h0;
         end
         else
            span_cnt_q <= span_cnt_q + 2'h1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         pixel_o <= `LDTP_NONLIT_PIXEL;
         non_lit_o <= 1'b1;
      end
      else
      begin
         non_lit_o <= !lit_w;
         if (!lit_w)
            pixel_o <= `LDTP_NONLIT_PIXEL;
         else if (eight_w)
            pixel_o <= {{6{pixel_i[17]}}, {6{pixel_i[11]}}, {6{pixel_i[5]}}};
         else
            pixel_o <= pixel_i;
      end
   end

   ldtp_gamma_sel u_gamma_sel (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .polarity_i(polarity_q),
      .eight_colour_i(eight_w),
      .pos_i(gpos_q),
      .neg_i(gneg_q),
      .gamma_o(gamma_o),
      .gray_enable_o(gray_enable_o),
      .low_tap_gray_o(low_tap_gray_o),
      .high_tap_gray_o(high_tap_gray_o)
   );

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   sequence rd_addr_s;
      req_w && !hwrite_i;
   endsequence
   sequence rd_data_s;
      !hreadyout_o ##1 hreadyout_o;
   endsequence
   sequence last_line_s;
      line_start_o && en_w && frame_wrap_w && !wr_pend_q;
   endsequence

   read_wait_a: assert property (rd_addr_s |=> rd_data_s)
      else $error("read data phase did not take exactly one wait state");
   frame_wrap_a: assert property (last_line_s |=> ##0 frame_start_o)
      else $error("frame did not restart after its last line period");
   frame_mark_a: assert property (frame_start_o |-> $past(line_start_o) && !disp_w && (phase_w != 2'b01))
      else $error("frame marker outside a frame boundary");
   blank_hold_a: assert property ((line_mode_w && !disp_w && $stable(ctrl_q)) |=> $stable(polarity_q))
      else $error("polarity alternated during porch lines");
   frame_toggle_a: assert property ((!line_mode_w && frame_start_o) |=> polarity_q != $past(polarity_q))
      else $error("frame inversion missed its toggle");
   span_only_a: assert property ((line_mode_w && !line_evt_q) |=> $stable(polarity_q))
      else $error("line inversion toggled away from a line boundary");
   eight_pix_a: assert property ((eight_w && lit_w) |=> pixel_o == {{6{$past(pixel_i[17])}},
      {6{$past(pixel_i[11])}}, {6{$past(pixel_i[5])}}})
      else $error("eight-colour pixel not msb replicated");
   nonlit_a: assert property (!lit_w |=> non_lit_o && (pixel_o == `LDTP_NONLIT_PIXEL))
      else $error("unselected line not driven non-lit");
endmodule

// ### ldtp_tb.sv
// self-checking bench for ldtp_top: ahb-lite register access, line and frame timing, polarity, pixels, gamma
// assumes the design's own assertions sit inside it; this bench only drives ports and compares
`timescale 1ns/1ps
`include "ldtp_cfg.svh"
module testbench;
   logic clk_i = 0, reset_i = 1, hsel_i = 0, hwrite_i = 0, hready_i, hreadyout_o, hresp_o;
   logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, gray_enable_o, rd;
   logic [1:0] htrans_i = 0;
   logic [2:0] hsize_i = 3'h2, reference_voltage_setting_o;
   logic [17:0] pixel_i = 0, pixel_o;
   logic drive_polarity_o, frame_start_o, line_start_o, display_line_o, non_lit_o, rdy;
   logic [4:0] low_tap_gray_o, high_tap_gray_o;
   ldtp_pkg::ldtp_gamma_s gamma_o;
   logic [31:0] ga_p, gb_p, ga_n, gb_n;
   integer seed = 32'hea8f4eba;
   int n_fail = 0, checked = 0, lin, eight, part, lcc, pre, span;
   localparam int NL = 9, FP = 2, BP = 3;

   always #12.5 clk_i = ~clk_i;
   // single slave: its ready is the bus ready
   assign hready_i = hreadyout_o;
   always @(posedge clk_i) pixel_i <= 18'($random(seed));

   ldtp_top dut (.clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
      .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
      .hreadyout_o(hreadyout_o), .hrdata_o(hrdata_o), .hresp_o(hresp_o), .pixel_i(pixel_i), .pixel_o(pixel_o),
      .drive_polarity_o(drive_polarity_o), .frame_start_o(frame_start_o), .line_start_o(line_start_o),
      .display_line_o(display_line_o), .non_lit_o(non_lit_o), .gamma_o(gamma_o), .gray_enable_o(gray_enable_o),
      .low_tap_gray_o(low_tap_gray_o), .high_tap_gray_o(high_tap_gray_o),
      .reference_voltage_setting_o(reference_voltage_setting_o));

   task report_and_stop;
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
      begin
         $display("DONE - PASS");
      end
      else
      begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task cmp_sig(input logic [63:0] got, input logic [63:0] exp, input string what);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      cmp_sig(64'(got), 64'(exp), "register read");
   endtask

   // ready and read data are taken at the rising edge, before the slave's flops update there
   task wait_rdy;
      int n;
      rdy = 0;
      for (n = 0; n < 40 && rdy !== 1'b1; n++)
      begin
         @(posedge clk_i);
         rdy = hreadyout_o;
         rd = hrdata_o;
      end
      if (rdy !== 1'b1)
      begin
         n_fail++;
         report_and_stop;
      end
   endtask

   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_i);
      hsel_i <= 1'b1;
      htrans_i <= 2'b10;
      hwrite_i <= w;
      haddr_i <= a;
      wait_rdy;
      hsel_i <= 1'b0;
      htrans_i <= 2'b00;
      hwdata_i <= d;
      wait_rdy;
      cmp_sig(64'(hresp_o), 64'h0, "response");
   endtask

   function automatic logic [17:0] rep(input logic [17:0] p);
      return {{6{p[17]}}, {6{p[11]}}, {6{p[5]}}};
   endfunction

   // observes one frame, from a frame marker to the next; chk off just syncs to the frame grid
   task frame_check(input bit chk);
      int c, lastls, row, flips, n, per;
      logic pol, lit;
      logic [17:0] pprev;
      logic [31:0] ga, gb;
      per = ((lcc < 16) ? 16 : lcc) * (pre + 1);
      for (n = 0; n < 5000 && frame_start_o !== 1'b1; n++) @(negedge clk_i);
      if (n == 5000)
      begin
         n_fail++;
         report_and_stop;
      end
      c = 0;
      lastls = -1;
      row = 0;
      flips = 0;
      pol = drive_polarity_o;
      pprev = pixel_i;
      for (n = 0; n < 5000; n++)
      begin
         @(negedge clk_i);
         c++;
         if (frame_start_o === 1'b1) break;
         if (drive_polarity_o !== pol)
         begin
            flips++;
            pol = drive_polarity_o;
            if (chk && lin) cmp_sig(64'(display_line_o), 64'h1, "flip in blank line");
            // the line event flag lands one cycle into the new line, the flip one cycle later
            if (chk && lin) cmp_sig(64'(c - 2), 64'(lastls), "flip off line boundary");
         end
         if (chk && line_start_o === 1'b1)
         begin
            cmp_sig(64'(c - lastls), 64'(per), "line length");
            lit = display_line_o && (!part || (row >= 2 && row <= 4) || row == 7);
            cmp_sig(64'(non_lit_o), 64'(!lit), "non-lit flag");
            cmp_sig(64'(pixel_o), 64'(!lit ? 18'h0 : (eight ? rep(pprev) : pprev)), "pixel");
            ga = drive_polarity_o ? ga_n : ga_p;
            gb = drive_polarity_o ? gb_n : gb_p;
            cmp_sig(64'(gamma_o), eight ? 64'({14'h0, ga[9:0], 18'h0}) : 64'({ga[23:0], gb[17:0]}), "gamma");
            cmp_sig(64'(gray_enable_o), eight ? 64'h80000001 : 64'hffffffff, "grayscale power");
            if (!eight) cmp_sig(64'(low_tap_gray_o), 64'(5'h03 + ga[19:18]), "low tap");
            if (!eight) cmp_sig(64'(high_tap_gray_o), 64'(5'h19 + ga[21:20]), "high tap");
            if (display_line_o === 1'b1) row++;
            lastls = c;
         end
         pprev = pixel_i;
      end
      if (n == 5000)
      begin
         n_fail++;
         report_and_stop;
      end
      if (chk)
      begin
         cmp_sig(64'(c), 64'(per * (NL + FP + BP)), "frame length");
         cmp_sig(64'(row), 64'(NL), "driven lines");
         cmp_sig(64'(flips), 64'(lin ? (NL - 1) / (span + 1) : 1), "polarity flips");
      end
   endtask

   initial
   begin
      repeat (8) @(posedge clk_i);
      reset_i <= 1'b0;
      @(negedge clk_i);
      cmp_sig(64'({hreadyout_o, non_lit_o, drive_polarity_o, frame_start_o}), 64'hc, "reset outputs");
      ahb(1'b1, 32'h0000002c, 32'hffffffff);
      ahb(1'b1, `LDTP_STATUS_OFS, 32'hffffffff);
      ahb(1'b0, `LDTP_CTRL_OFS, 32'h0);
      cmp_reg(rd, 32'h0);
      ahb(1'b0, `LDTP_TIMING_OFS, 32'h0);
      cmp_reg(rd, 32'h00000019);
      ahb(1'b0, `LDTP_LINES_OFS, 32'h0);
      cmp_reg(rd, 32'h0e0201b0);
      ahb(1'b0, `LDTP_VREF_OFS, 32'h0);
      cmp_reg(rd, 32'h0);
      ahb(1'b0, 32'h0000002c, 32'h0);
      cmp_reg(rd, 32'h0);
      ahb(1'b0, `LDTP_STATUS_OFS, 32'h0);
      cmp_reg(rd, 32'h0);
      ahb(1'b1, `LDTP_VREF_OFS, 32'h7);
      ahb(1'b0, `LDTP_VREF_OFS, 32'h0);
      cmp_reg(rd, 32'h7);
      cmp_sig(64'(reference_voltage_setting_o), 64'h7, "reference setting");
      ga_p = $random(seed) & 32'h00ffffff;
      gb_p = $random(seed) & 32'h0003ffff;
      ga_n = $random(seed) & 32'h00ffffff;
      gb_n = $random(seed) & 32'h0003ffff;
      ahb(1'b1, `LDTP_GPOS_A_OFS, ga_p);
      ahb(1'b1, `LDTP_GPOS_B_OFS, gb_p);
      ahb(1'b1, `LDTP_GNEG_A_OFS, ga_n);
      ahb(1'b1, `LDTP_GNEG_B_OFS, gb_n);
      ahb(1'b0, `LDTP_GNEG_A_OFS, 32'h0);
      cmp_reg(rd, ga_n);
      ahb(1'b1, `LDTP_LINES_OFS, {8'd3, 8'd2, 7'h0, 9'd9});
      ahb(1'b1, `LDTP_PART1_OFS, {7'h0, 9'd4, 7'h0, 9'd2});
      ahb(1'b1, `LDTP_PART2_OFS, {7'h0, 9'd7, 7'h0, 9'd7});
      // frame mode first, then every line span; code 5 checks the clamp to 16 clocks
      // prescale codes 2 and 3 ride on the last two line spans
      for (int i = 0; i < 7; i++)
      begin
         lin = (i >= 3);
         eight = i % 2;
         part = (i % 3 == 1);
         pre = (i == 1 || i == 4) ? 1 : (i >= 5) ? i - 3 : 0;
         span = lin ? i - 3 : 0;
         lcc = (i == 2) ? 5 : (i == 1) ? 31 : 16 + ($random(seed) & 15);
         ahb(1'b1, `LDTP_TIMING_OFS, {14'h0, 2'(span), 6'h0, 2'(pre), 3'h0, 5'(lcc)});
         ahb(1'b1, `LDTP_CTRL_OFS, {28'h0, 1'(part), 1'(eight), 1'(lin), 1'b1});
         frame_check(1'b0);
         frame_check(1'b1);
      end
      report_and_stop;
   end
endmodule
